// ---- core/regulator_profile_pkg.sv ----
package regulator_profile_pkg;

    // Register addresses on the serial bus.
    localparam logic [7:0] ADDR_PROFILE_THREE = 8'h03;
    localparam logic [7:0] ADDR_PULLDOWN      = 8'h04;
    localparam logic [7:0] ADDR_CLOCK_FREQ    = 8'h05;
    localparam logic [7:0] ADDR_SLEW          = 8'h06;

    // Reset values.
    localparam logic [7:0] RST_PROFILE_THREE = 8'h9e;
    localparam logic [7:0] RST_PULLDOWN      = 8'he0;
    localparam logic [7:0] RST_CLOCK_FREQ    = 8'h00;
    localparam logic [7:0] RST_SLEW          = 8'h01;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;

    // Writable bits of the two read/write registers.
    localparam logic [7:0] MASK_PROFILE = 8'hff;
    localparam logic [7:0] MASK_PULLDOWN = 8'he0;

    // Profile register fields.
    localparam int PWM_FORCE_BIT    = 7;
    localparam int CLOCK_FOLLOW_BIT = 6;
    localparam int VOUT_MSB         = 5;
    localparam int VOUT_W           = 6;

    // Pulldown register fields.
    localparam int ENABLE_PIN_PULLDOWN_BIT   = 7;
    localparam int SEL0_PD_BIT = 6;
    localparam int SEL1_PD_BIT = 5;

    // Clock frequency field and slew register fields.
    localparam int FREQ_MSB       = 7;
    localparam int FREQ_LSB       = 6;
    localparam int SLEW_MSB       = 7;
    localparam int SLEW_LSB       = 5;
    localparam int POWER_SAVE_BIT = 4;
    localparam int KEEP_OSC_BIT   = 3;
    localparam int RAMP_DOWN_BIT  = 1;

    // Profile selection codes from {select_pin1, select_pin0}.
    localparam logic [1:0] SEL_PROFILE_ZERO  = 2'h0;
    localparam logic [1:0] SEL_PROFILE_ONE   = 2'h1;
    localparam logic [1:0] SEL_PROFILE_TWO   = 2'h2;
    localparam logic [1:0] SEL_PROFILE_THREE = 2'h3;

    // Serial bus agent address; the value is arbitrary.
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h4a;
    localparam logic [2:0] LAST_BIT         = 3'h7;

    // Pin synchroniser layout and idle levels.
    localparam int PIN_W      = 7;
    localparam int PIN_SCL    = 0;
    localparam int PIN_SDA    = 1;
    localparam int PIN_SEL0   = 2;
    localparam int PIN_SEL1   = 3;
    localparam int PIN_EN     = 4;
    localparam int PIN_UVLO_L = 5;
    localparam int PIN_UVLO_P = 6;
    localparam logic [PIN_W-1:0] PIN_IDLE = 7'h13;

    // One output-voltage profile.
    typedef struct packed {
        logic              pwm_force;
        logic              clock_follow;
        logic [VOUT_W-1:0] vout_code;
    } profile_s;

    // Bus FSM states.
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } bus_state_e;

endpackage

// ---- core/pin_sync3.sv ----
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int         W         = 1,
    parameter logic [W-1:0] IDLE_VAL = '0
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic [W-1:0]      level
);

    ////////////////////////////////////////////////////////////////////////////
    // Three stages per bit; the level moves once stages two and three agree.
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    s1_r     <= IDLE_VAL[i];
                    s2_r     <= IDLE_VAL[i];
                    s3_r     <= IDLE_VAL[i];
                    level[i] <= IDLE_VAL[i];
                end
                else
                begin
                    s1_r <= async_in[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r)
                    begin
                        level[i] <= s3_r;
                    end
                end
            end
        end
    endgenerate

endmodule

// ---- core/regulator_profile_control_regs.sv ----
`timescale 1ns/1ps
import regulator_profile_pkg::*;

module regulator_profile_control_regs #(
    parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         scl,
    input  wire logic         sda_in,
    output logic              sda_out,
    output logic              sda_oe,
    input  wire logic         select_pin0,
    input  wire logic         select_pin1,
    input  wire logic         enable_pin,
    input  wire logic         uvlo_logic,
    input  wire logic         uvlo_power_input,
    input  wire profile_s     profile_zero,
    input  wire profile_s     profile_one,
    input  wire profile_s     profile_two,
    output profile_s          active_profile,
    output logic              enable_pin_pulldown,
    output logic              select_pin0_pulldown,
    output logic              select_pin1_pulldown,
    output logic [1:0]        ext_clock_freq,
    output logic [2:0]        slew_rate_code,
    output logic              pin_power_save,
    output logic              keep_oscillator_on,
    output logic              active_ramp_down
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;

    // All pins come from outside the clock domain.
    assign pins_raw = {uvlo_power_input, uvlo_logic, enable_pin, select_pin1,
                       select_pin0, sda_in, scl};

    pin_sync3 #(
        .W        (PIN_W),
        .IDLE_VAL (PIN_IDLE)
    ) u_pin_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (pins_raw),
        .level    (pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus edge and condition detection on the filtered levels.

    logic scl_prev_r;
    logic sda_prev_r;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic uvlo_any;

    // Previous levels for edge detection.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end
        else
        begin
            scl_prev_r <= pins_s[PIN_SCL];
            sda_prev_r <= pins_s[PIN_SDA];
        end
    end

    // Start and stop are data edges while the bus clock is high.
    assign scl_rise  = pins_s[PIN_SCL] & ~scl_prev_r;
    assign scl_fall  = ~pins_s[PIN_SCL] & scl_prev_r;
    assign bus_start = pins_s[PIN_SCL] & scl_prev_r & sda_prev_r & ~pins_s[PIN_SDA];
    assign bus_stop  = pins_s[PIN_SCL] & scl_prev_r & ~sda_prev_r & pins_s[PIN_SDA];
    assign uvlo_any  = pins_s[PIN_UVLO_L] | pins_s[PIN_UVLO_P];

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [7:0] profile_three_ctrl_r;
    logic [7:0] pin_pulldown_ctrl_r;
    logic [7:0] ext_clock_freq_sel_r;
    logic [7:0] slew_power_save_ctrl_r;
    logic [7:0] rd_data;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic       full_r;
    logic       wr_fire;
    bus_state_e state_r;

    // A byte is committed on the falling clock edge that ends its last bit.
    assign wr_fire = (state_r == ST_WDATA) && scl_fall && full_r;

    // Profile three: writable, restored on either supply lockout.
    always_ff @(posedge clock)
    begin
        if (rst || uvlo_any)
        begin
            profile_three_ctrl_r <= RST_PROFILE_THREE;
        end
        else if (wr_fire && ptr_r == ADDR_PROFILE_THREE)
        begin
            profile_three_ctrl_r <= shift_r & MASK_PROFILE;
        end
    end

    // Pulldown control: also restored whenever the enable pin sits low.
    always_ff @(posedge clock)
    begin
        if (rst || uvlo_any || !pins_s[PIN_EN])
        begin
            pin_pulldown_ctrl_r <= RST_PULLDOWN;
        end
        else if (wr_fire && ptr_r == ADDR_PULLDOWN)
        begin
            pin_pulldown_ctrl_r <= shift_r & MASK_PULLDOWN;
        end
    end

    // Read-only registers have no write path, so bus writes are dropped.
    always_ff @(posedge clock)
    begin
        if (rst || uvlo_any)
        begin
            ext_clock_freq_sel_r   <= RST_CLOCK_FREQ;
            slew_power_save_ctrl_r <= RST_SLEW;
        end
    end

    // Read multiplexer; addresses outside this bank read as zero.
    always_comb
    begin
        case (ptr_r)
            ADDR_PROFILE_THREE: rd_data = profile_three_ctrl_r;
            ADDR_PULLDOWN:      rd_data = pin_pulldown_ctrl_r;
            ADDR_CLOCK_FREQ:    rd_data = ext_clock_freq_sel_r;
            ADDR_SLEW:          rd_data = slew_power_save_ctrl_r;
            default:            rd_data = READ_UNMAPPED;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial bus agent: sample on rising clock, change data after falling.

    logic [2:0] bit_cnt_r;
    logic       rw_r;
    logic       oe_r;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r   <= ST_IDLE;
            shift_r   <= 8'h00;
            ptr_r     <= 8'h00;
            bit_cnt_r <= 3'h0;
            full_r    <= 1'b0;
            rw_r      <= 1'b0;
            oe_r      <= 1'b0;
        end
        else if (bus_start)
        begin
            // A repeated start keeps the pointer for a following read.
            state_r   <= ST_ADDR;
            bit_cnt_r <= 3'h0;
            full_r    <= 1'b0;
            oe_r      <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_r <= ST_IDLE;
            oe_r    <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_ADDR, ST_PTR, ST_WDATA:
                begin
                    if (scl_rise && !full_r)
                    begin
                        shift_r   <= {shift_r[6:0], pins_s[PIN_SDA]};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        full_r    <= (bit_cnt_r == LAST_BIT);
                    end
                    else if (scl_fall && full_r)
                    begin
                        full_r <= 1'b0;
                        if (state_r == ST_ADDR)
                        begin
                            if (shift_r[7:1] == BUS_ADDR)
                            begin
                                rw_r    <= shift_r[0];
                                oe_r    <= 1'b1;
                                state_r <= ST_ADDR_ACK;
                            end
                            else
                            begin
                                state_r <= ST_IDLE;
                            end
                        end
                        else if (state_r == ST_PTR)
                        begin
                            ptr_r   <= shift_r;
                            oe_r    <= 1'b1;
                            state_r <= ST_PTR_ACK;
                        end
                        else
                        begin
                            // Every byte is acknowledged, even when dropped.
                            ptr_r   <= ptr_r + 8'h01;
                            oe_r    <= 1'b1;
                            state_r <= ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RDATA_ACK:
                begin
                    if (state_r == ST_RDATA_ACK && scl_rise && pins_s[PIN_SDA])
                    begin
                        state_r <= ST_IDLE;
                    end
                    else if (scl_fall && (rw_r || state_r == ST_RDATA_ACK))
                    begin
                        shift_r   <= rd_data;
                        ptr_r     <= ptr_r + 8'h01;
                        oe_r      <= ~rd_data[7];
                        bit_cnt_r <= 3'h0;
                        state_r   <= ST_RDATA;
                    end
                    else if (scl_fall)
                    begin
                        oe_r    <= 1'b0;
                        state_r <= ST_PTR;
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_r    <= 1'b0;
                        state_r <= ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == LAST_BIT)
                        begin
                            oe_r    <= 1'b0;
                            state_r <= ST_RDATA_ACK;
                        end
                        else
                        begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            oe_r    <= ~shift_r[6];
                        end
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                    end
                end
                default:
                begin
                    oe_r <= 1'b0;
                end
            endcase
        end
    end

    // The data pin is open drain: it only ever pulls low.
    assign sda_oe  = oe_r;
    assign sda_out = 1'b0 & oe_r;

    ////////////////////////////////////////////////////////////////////////////
    // Active profile selection, reevaluated every cycle from the pins.

    profile_s sel_profile;
    profile_s prof3;

    assign prof3.pwm_force    = profile_three_ctrl_r[PWM_FORCE_BIT];
    assign prof3.clock_follow = profile_three_ctrl_r[CLOCK_FOLLOW_BIT];
    assign prof3.vout_code    = profile_three_ctrl_r[VOUT_MSB:0];

    // Profiles zero to two live outside this bank and arrive as inputs.
    always_comb
    begin
        case ({pins_s[PIN_SEL1], pins_s[PIN_SEL0]})
            SEL_PROFILE_ZERO:  sel_profile = profile_zero;
            SEL_PROFILE_ONE:   sel_profile = profile_one;
            SEL_PROFILE_TWO:   sel_profile = profile_two;
            SEL_PROFILE_THREE: sel_profile = prof3;
            default:           sel_profile = profile_zero;
        endcase
    end

    // Registered so every output but the constant sda_out comes straight from a flip-flop.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            active_profile <= '0;
        end
        else
        begin
            active_profile <= sel_profile;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs decoded from the register fields.

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            enable_pin_pulldown  <= RST_PULLDOWN[ENABLE_PIN_PULLDOWN_BIT];
            select_pin0_pulldown <= RST_PULLDOWN[SEL0_PD_BIT];
            select_pin1_pulldown <= RST_PULLDOWN[SEL1_PD_BIT];
        end
        else
        begin
            enable_pin_pulldown  <= pin_pulldown_ctrl_r[ENABLE_PIN_PULLDOWN_BIT];
            select_pin0_pulldown <= pin_pulldown_ctrl_r[SEL0_PD_BIT];
            select_pin1_pulldown <= pin_pulldown_ctrl_r[SEL1_PD_BIT];
        end
    end

    // Power-save force is ignored while the pin-selected profile (sel_profile, before its register) forces PWM.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ext_clock_freq     <= RST_CLOCK_FREQ[FREQ_MSB:FREQ_LSB];
            slew_rate_code     <= RST_SLEW[SLEW_MSB:SLEW_LSB];
            pin_power_save     <= 1'b0;
            keep_oscillator_on <= RST_SLEW[KEEP_OSC_BIT];
            active_ramp_down   <= RST_SLEW[RAMP_DOWN_BIT];
        end
        else
        begin
            ext_clock_freq     <= ext_clock_freq_sel_r[FREQ_MSB:FREQ_LSB];
            slew_rate_code     <= slew_power_save_ctrl_r[SLEW_MSB:SLEW_LSB];
            pin_power_save     <= slew_power_save_ctrl_r[POWER_SAVE_BIT]
                                  & ~sel_profile.pwm_force;
            keep_oscillator_on <= slew_power_save_ctrl_r[KEEP_OSC_BIT];
            active_ramp_down   <= slew_power_save_ctrl_r[RAMP_DOWN_BIT];
        end
    end

endmodule

// ---- verification/regulator_profile_chk.sv ----
`timescale 1ns/1ps
module regulator_profile_chk import regulator_profile_pkg::*; (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       sda_oe,
    input wire logic       select_pin0,
    input wire logic       select_pin1,
    input wire logic       enable_pin,
    input wire logic       uvlo_logic,
    input wire logic       uvlo_power_input,
    input wire profile_s   profile_zero,
    input wire profile_s   profile_one,
    input wire profile_s   profile_two,
    input wire profile_s   active_profile,
    input wire logic       enable_pin_pulldown,
    input wire logic       select_pin0_pulldown,
    input wire logic       select_pin1_pulldown,
    input wire logic [1:0] ext_clock_freq,
    input wire logic [2:0] slew_rate_code,
    input wire logic       pin_power_save,
    input wire logic       keep_oscillator_on,
    input wire logic       active_ramp_down
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Synchronised pins get eight steady cycles.
    property p_reset_values;
        disable iff (1'b0) rst |=> enable_pin_pulldown && select_pin0_pulldown && select_pin1_pulldown && !sda_oe;
    endproperty
    property p_freq_fixed;
        ext_clock_freq == 2'h0;
    endproperty
    property p_slew_fixed;
        slew_rate_code == 3'h0 && !keep_oscillator_on && !active_ramp_down;
    endproperty
    property p_power_save;
        !pin_power_save;
    endproperty
    property p_enable_low;
        !enable_pin [*8] |=> enable_pin_pulldown && select_pin0_pulldown && select_pin1_pulldown;
    endproperty
    property p_uvlo_defaults;
        ((uvlo_logic || uvlo_power_input) && select_pin0 && select_pin1) [*8]
            |=> active_profile == RST_PROFILE_THREE && enable_pin_pulldown && select_pin1_pulldown;
    endproperty
    property p_sel_zero;
        (!select_pin0 && !select_pin1 && $stable(profile_zero)) [*8] |-> active_profile == profile_zero;
    endproperty
    property p_sel_one;
        (select_pin0 && !select_pin1 && $stable(profile_one)) [*8] |-> active_profile == profile_one;
    endproperty
    property p_sel_two;
        (!select_pin0 && select_pin1 && $stable(profile_two)) [*8] |-> active_profile == profile_two;
    endproperty

    a_reset_values: assert property (p_reset_values) else $error("pulldowns not set after reset");
    a_freq_fixed: assert property (p_freq_fixed) else $error("frequency field moved");
    a_slew_fixed: assert property (p_slew_fixed) else $error("slew fields moved");
    a_power_save: assert property (p_power_save) else $error("power save forced");
    a_enable_low: assert property (p_enable_low) else $error("pulldowns not restored");
    a_uvlo_defaults: assert property (p_uvlo_defaults) else $error("lockout defaults missing");
    a_sel_zero: assert property (p_sel_zero) else $error("profile zero not applied");
    a_sel_one: assert property (p_sel_one) else $error("profile one not applied");
    a_sel_two: assert property (p_sel_two) else $error("profile two not applied");

    c_bus_answer: cover property ($rose(sda_oe));
    c_enable_low: cover property ($fell(enable_pin));
    c_uvlo: cover property ($rose(uvlo_power_input));
endmodule

bind regulator_profile_control_regs regulator_profile_chk u_chk (
    .clock(clock), .rst(rst), .sda_oe(sda_oe), .select_pin0(select_pin0), .select_pin1(select_pin1),
    .enable_pin(enable_pin), .uvlo_logic(uvlo_logic), .uvlo_power_input(uvlo_power_input),
    .profile_zero(profile_zero), .profile_one(profile_one), .profile_two(profile_two),
    .active_profile(active_profile), .enable_pin_pulldown(enable_pin_pulldown),
    .select_pin0_pulldown(select_pin0_pulldown), .select_pin1_pulldown(select_pin1_pulldown),
    .ext_clock_freq(ext_clock_freq), .slew_rate_code(slew_rate_code), .pin_power_save(pin_power_save),
    .keep_oscillator_on(keep_oscillator_on), .active_ramp_down(active_ramp_down)
);

// ---- verification/i2c_host_model.sv ----
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    // Serial clock half period; the filter needs four cycles or more.
    localparam int HALF = 12;

    // Both lines start released.
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Data moves mid low phase and is sampled at the end of the high phase.
    task automatic bit_io(input logic b, output logic r);
        @(posedge clock) sda_drv <= b;
        repeat (HALF / 2) @(posedge clock);
        scl <= 1'b1;
        repeat (HALF) @(posedge clock);
        r = sda;
        scl <= 1'b0;
        repeat (HALF / 2) @(posedge clock);
    endtask

    task automatic start_cond();
        @(posedge clock) sda_drv <= 1'b1;
        repeat (HALF / 2) @(posedge clock);
        scl <= 1'b1;
        repeat (HALF) @(posedge clock);
        sda_drv <= 1'b0;
        repeat (HALF) @(posedge clock);
        scl <= 1'b0;
        repeat (HALF / 2) @(posedge clock);
    endtask

    task automatic stop_cond();
        @(posedge clock) sda_drv <= 1'b0;
        repeat (HALF / 2) @(posedge clock);
        scl <= 1'b1;
        repeat (HALF) @(posedge clock);
        sda_drv <= 1'b1;
        repeat (HALF) @(posedge clock);
    endtask

    // MSB first, then the acknowledge slot.
    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ack_in, ack);
    endtask

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data,
                             output logic nack);
        logic [7:0] q;
        logic [2:0] a;
        start_cond();
        byte_io({dev, 1'b0}, 1'b1, q, a[0]);
        byte_io(ptr, 1'b1, q, a[1]);
        byte_io(data, 1'b1, q, a[2]);
        stop_cond();
        nack = |a;
    endtask

    // A read ends with a refused acknowledge.
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] data,
                            output logic nack);
        logic [7:0] q;
        logic [2:0] a;
        logic       dn;
        start_cond();
        byte_io({dev, 1'b0}, 1'b1, q, a[0]);
        byte_io(ptr, 1'b1, q, a[1]);
        start_cond();
        byte_io({dev, 1'b1}, 1'b1, q, a[2]);
        byte_io(8'hff, 1'b1, data, dn);
        stop_cond();
        nack = |a;
    endtask
endmodule

// ---- verification/regulator_profile_control_regs_bench.sv ----
`timescale 1ns/1ps
module regulator_profile_control_regs_bench import regulator_profile_pkg::*;;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       select_pin0 = 1'b1;
    logic       select_pin1 = 1'b1;
    logic       enable_pin = 1'b1;
    logic       uvlo_logic = 1'b0;
    logic       uvlo_power_input = 1'b0;
    profile_s   profile_zero = 8'h11;
    profile_s   profile_one = 8'h62;
    profile_s   profile_two = 8'hb3;
    logic       scl;
    logic       sda_drv;
    logic       sda_out;
    logic       sda_oe;
    profile_s   active_profile;
    logic       enable_pin_pulldown;
    logic       select_pin0_pulldown;
    logic       select_pin1_pulldown;
    logic [1:0] ext_clock_freq;
    logic [2:0] slew_rate_code;
    logic       pin_power_save;
    logic       keep_oscillator_on;
    logic       active_ramp_down;
    logic       nack;
    wire logic  sda;
    int         failures = 0;
    int         total_checks = 0;
    logic [7:0] prof_tab [2] = '{8'h25, 8'hda};
    logic [7:0] sel_tab [4] = '{8'h11, 8'h62, 8'hb3, 8'h9e};

    ////////////////////////////////////////
    always #5 clock = ~clock;

    // Wired-AND data line with pull-up.
    assign sda = (sda_oe ? sda_out : 1'b1) & sda_drv;

    regulator_profile_control_regs u_dut (
        .clock(clock), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .select_pin0(select_pin0), .select_pin1(select_pin1), .enable_pin(enable_pin),
        .uvlo_logic(uvlo_logic), .uvlo_power_input(uvlo_power_input), .profile_zero(profile_zero),
        .profile_one(profile_one), .profile_two(profile_two), .active_profile(active_profile),
        .enable_pin_pulldown(enable_pin_pulldown), .select_pin0_pulldown(select_pin0_pulldown),
        .select_pin1_pulldown(select_pin1_pulldown), .ext_clock_freq(ext_clock_freq),
        .slew_rate_code(slew_rate_code), .pin_power_save(pin_power_save),
        .keep_oscillator_on(keep_oscillator_on), .active_ramp_down(active_ramp_down)
    );

    i2c_host_model u_host (.clock(clock), .sda(sda), .scl(scl), .sda_drv(sda_drv));

    ////////////////////////////////////////
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_ack(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: acknowledge %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic n;
        u_host.write_reg(BUS_ADDR_DEFAULT, a, d, n);
        check_ack(n, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic       n;
        u_host.read_reg(BUS_ADDR_DEFAULT, a, q, n);
        check_ack(n, 1'b0);
        check_val(q, exp);
    endtask

    task automatic check_pd(input logic [7:0] exp);
        check_val({enable_pin_pulldown, select_pin0_pulldown, select_pin1_pulldown, 5'h0}, exp);
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////
    // Watchdog span is well beyond the expected run.
    initial
    begin
        repeat (80000) @(posedge clock);
        failures++;
        close_out();
    end

    // Reset, then one group of calls per behaviour.
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (10) @(posedge clock);
        check_pd(8'he0);
        check_val({slew_rate_code, pin_power_save, keep_oscillator_on, active_ramp_down, ext_clock_freq}, 8'h00);
        check_val(active_profile, 8'h9e);
        rd(8'h03, 8'h9e);
        rd(8'h04, 8'he0);
        rd(8'h05, 8'h00);
        rd(8'h06, 8'h01);
        $display("Test reset values done");
        for (int i = 0; i < 2; i++)
        begin
            wr(ADDR_PROFILE_THREE, prof_tab[i]);
            rd(ADDR_PROFILE_THREE, prof_tab[i]);
            check_val(active_profile, prof_tab[i]);
            check_val({7'h0, pin_power_save}, 8'h00);
        end
        $display("Test profile three done");
        wr(ADDR_PULLDOWN, 8'h1f);
        rd(ADDR_PULLDOWN, 8'h00);
        check_pd(8'h00);
        wr(ADDR_PULLDOWN, 8'h5f);
        rd(ADDR_PULLDOWN, 8'h40);
        check_pd(8'h40);
        $display("Test pulldown control done");
        wr(ADDR_CLOCK_FREQ, 8'hc0);
        wr(ADDR_SLEW, 8'hfe);
        rd(ADDR_CLOCK_FREQ, 8'h00);
        rd(ADDR_SLEW, 8'h01);
        u_host.write_reg(7'h4b, ADDR_PROFILE_THREE, 8'h00, nack);
        check_ack(nack, 1'b1);
        rd(ADDR_PROFILE_THREE, 8'hda);
        $display("Test read only done");
        @(posedge clock) enable_pin <= 1'b0;
        repeat (10) @(posedge clock);
        check_pd(8'he0);
        rd(ADDR_PULLDOWN, 8'he0);
        @(posedge clock) enable_pin <= 1'b1;
        rd(ADDR_PROFILE_THREE, 8'hda);
        $display("Test enable low done");
        // Each lockout source alone restores defaults.
        for (int k = 0; k < 2; k++)
        begin
            wr(ADDR_PULLDOWN, 8'h00);
            wr(ADDR_PROFILE_THREE, 8'h3c);
            @(posedge clock) {uvlo_power_input, uvlo_logic} <= 2'(1 << k);
            repeat (10) @(posedge clock);
            check_val(active_profile, 8'h9e);
            check_pd(8'he0);
            {uvlo_power_input, uvlo_logic} <= 2'h0;
            repeat (10) @(posedge clock);
            rd(ADDR_PROFILE_THREE, 8'h9e);
            rd(ADDR_PULLDOWN, 8'he0);
        end
        $display("Test lockout done");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clock) {select_pin1, select_pin0} <= 2'(k);
            repeat (10) @(posedge clock);
            check_val(active_profile, sel_tab[k]);
        end
        $display("Test profile select done");
        close_out();
    end
endmodule
